/* ide_glue.sv */
// Drive interface glue: range decode, chip selects, bit 7 steer, latches.
// Assumes host strobes and drive pins are synchronous to core_clk_in.
// Functional notes
// R1: Drive bit 7 toward drive for writes to 1F0-1F7h and 3F6h, or 170-177h and 376h, per the selected address set.
// R2: Bit 7 line floats during accesses to 3F7h and 377h.
// R3: High-byte latch enable only when drive answers with 16-bit select.
// R4: Low-byte latch enable on every drive access, 8 or 16 bit.
// R5: Both latch enables inactive while drive interface is disabled.
// R6: DMA acknowledge input honoured only while control bit 1 is set.
// R7: 16-bit select input used only while config bit 2 is zero.
// R8: A 16-bit capable peripheral drives the 16-bit select input.
// R9: Chip select 0 for command block of the selected address set.
// R10: Chip select 1 for control block; off while interface disabled.
// R11: Latch enables active low, idle high outside accesses and at reset.
module ide_glue
    import ide_glue_pkg::*;
(
    input  wire logic                        core_clk_in,
    input  wire logic                        arst_n_in,
    input  wire ide_glue_pkg::ide_glue_host_s host_in,
    input  wire ide_glue_pkg::ide_glue_cfg_s  cfg_in,
    input  wire logic [7:0]                  host_data_in,
    input  wire logic                        drive_dma_ack_n_in,
    input  wire logic                        io_cs16_n_in,
    input  wire logic                        drive_data_bit7_in,
    output logic                             drive_data_bit7_out,
    output logic                             drive_data_bit7_oe_n_out,
    output logic                             host_data_bit7_out,
    output logic                             drive_chip_select_0_n_out,
    output logic                             drive_chip_select_1_n_out,
    output logic                             low_byte_latch_en_n_out,
    output logic                             high_byte_latch_en_n_out
);
    import ide_glue_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic [9:0] addr       = host_in.addr;
    wire logic       strobe     = host_in.rd | host_in.wr;
    wire logic       dma_mode   =
        cfg_in.function_control_reg[FCR_DMA_ACK_BIT] == DMA_ACK_VALUE; // R6
    wire logic       dma_access = dma_mode & ~drive_dma_ack_n_in; // R6
    wire logic       io_cycle   = strobe & ~host_in.aen;
    wire logic       pri_cmd    =
        addr[9:CMD_LOW_BITS] == PRI_CMD_BASE[9:CMD_LOW_BITS];
    wire logic       sec_cmd    =
        addr[9:CMD_LOW_BITS] == SEC_CMD_BASE[9:CMD_LOW_BITS];
    wire logic       pri_ctl    =
        addr[9:CTL_LOW_BITS] == PRI_CTL_BASE[9:CTL_LOW_BITS];
    wire logic       sec_ctl    =
        addr[9:CTL_LOW_BITS] == SEC_CTL_BASE[9:CTL_LOW_BITS];
    wire logic       cmd_hit    =
        cfg_in.secondary ? sec_cmd : pri_cmd; // R9
    wire logic       ctl_hit    =
        cfg_in.secondary ? sec_ctl : pri_ctl; // R10
    wire logic       ctl_hi     =
        cfg_in.secondary ? (addr == SEC_CTL_HI) : (addr == PRI_CTL_HI);
    wire logic       cmd_sel    =
        cfg_in.ide_enable & ((io_cycle & cmd_hit) | dma_access); // R9
    wire logic       ctl_sel    =
        cfg_in.ide_enable & io_cycle & ctl_hit; // R10
    wire logic       drive_acc  = cmd_sel | ctl_sel;
    wire logic       bit7_drive =
        cfg_in.ide_enable & strobe
        & ((io_cycle & ((cmd_hit | ctl_hit) & ~ctl_hi)) | dma_access); // R1 R2
    wire logic       cs16_use   =
        cfg_in.advanced_support_cfg[ASC_NO_CS16_BIT] == CS16_USE_VALUE; // R7
    wire logic       wide       = cs16_use & ~io_cs16_n_in; // R3 R8

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    wire logic cs0_next  = ~cmd_sel;
    wire logic cs1_next  = ~ctl_sel;
    wire logic lo_next   = ~(cfg_in.ide_enable & drive_acc); // R4 R5
    wire logic hi_next   =
        ~(cfg_in.ide_enable & drive_acc & wide); // R3 R5
    wire logic oe_next   = ~(bit7_drive & host_in.wr); // R1 R2
    wire logic d7_next   = host_data_in[7];
    wire logic rd7_next  = drive_data_bit7_in;

    logic cs0_reg;
    logic cs1_reg;
    logic lo_reg;
    logic hi_reg;
    logic oe_reg;
    logic d7_reg;
    logic rd7_reg;

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cs0_reg <= SEL_IDLE;
        end else begin
            cs0_reg <= cs0_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cs1_reg <= SEL_IDLE;
        end else begin
            cs1_reg <= cs1_next;
        end
    end

    // ------------------------------------------------------------------
    // Latch enables
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lo_reg <= SEL_IDLE; // R11
        end else begin
            lo_reg <= lo_next; // R11
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hi_reg <= SEL_IDLE; // R11
        end else begin
            hi_reg <= hi_next; // R11
        end
    end

    // ------------------------------------------------------------------
    // Bit 7 steering
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            oe_reg <= OE_OFF;
        end else begin
            oe_reg <= oe_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            d7_reg <= 1'b0;
        end else begin
            d7_reg <= d7_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd7_reg <= 1'b0;
        end else begin
            rd7_reg <= rd7_next;
        end
    end

    // ------------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------------

    assign drive_chip_select_0_n_out = cs0_reg;
    assign drive_chip_select_1_n_out = cs1_reg;
    assign low_byte_latch_en_n_out   = lo_reg;
    assign high_byte_latch_en_n_out  = hi_reg;
    assign drive_data_bit7_oe_n_out  = oe_reg;
    assign drive_data_bit7_out       = d7_reg;
    assign host_data_bit7_out        = rd7_reg;
endmodule : ide_glue

/* ide_glue_pkg.sv */
// Package for the drive interface glue: address ranges, field positions.
// Assumes a 10-bit host I/O address and one 20 MHz core clock.
package ide_glue_pkg;
    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 10;
    localparam logic [9:0]  PRI_CMD_BASE    = 10'h1F0;
    localparam logic [9:0]  SEC_CMD_BASE    = 10'h170;
    localparam logic [9:0]  PRI_CTL_BASE    = 10'h3F6;
    localparam logic [9:0]  SEC_CTL_BASE    = 10'h376;
    localparam logic [9:0]  PRI_CTL_HI      = 10'h3F7;
    localparam logic [9:0]  SEC_CTL_HI      = 10'h377;
    localparam int          CMD_LOW_BITS    = 3;
    localparam int          CTL_LOW_BITS    = 1;
    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int          FCR_DMA_ACK_BIT = 1;
    localparam int          ASC_NO_CS16_BIT = 2;
    localparam logic        CS16_USE_VALUE  = 1'b0;
    localparam logic        DMA_ACK_VALUE   = 1'b1;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic        SEL_IDLE        = 1'b1;
    localparam logic        OE_OFF          = 1'b1;

    typedef struct packed {
        logic [9:0] addr;
        logic       rd;
        logic       wr;
        logic       aen;
    } ide_glue_host_s;

    typedef struct packed {
        logic       ide_enable;
        logic       secondary;
        logic [7:0] function_control_reg;
        logic [7:0] advanced_support_cfg;
    } ide_glue_cfg_s;
endpackage : ide_glue_pkg

/* ide_glue_asserts.sv */
// Port checker for the drive glue.
// Assumes it is bound into every ide_glue instance.
module ide_glue_asserts import ide_glue_pkg::*; (
    input wire logic core_clk_in, arst_n_in, drive_dma_ack_n_in,
    input wire logic io_cs16_n_in, drive_data_bit7_out,
    input wire logic drive_data_bit7_oe_n_out, drive_chip_select_0_n_out,
    input wire logic drive_chip_select_1_n_out, low_byte_latch_en_n_out,
    input wire logic high_byte_latch_en_n_out,
    input wire logic [7:0] host_data_in,
    input wire ide_glue_pkg::ide_glue_host_s host_in,
    input wire ide_glue_pkg::ide_glue_cfg_s cfg_in);
    wire c0 = drive_chip_select_0_n_out, c1 = drive_chip_select_1_n_out;
    wire lo = low_byte_latch_en_n_out, hi = high_byte_latch_en_n_out;
    wire oe = drive_data_bit7_oe_n_out, d7 = drive_data_bit7_out;
    wire stb = cfg_in.ide_enable & (host_in.rd | host_in.wr);
    wire act = stb & ~host_in.aen;
    wire [9:0] cb = cfg_in.secondary ? SEC_CMD_BASE : PRI_CMD_BASE;
    wire [9:0] kb = cfg_in.secondary ? SEC_CTL_BASE : PRI_CTL_BASE;
    wire cmd = act && host_in.addr[9:3] == cb[9:3];
    wire ctl = act && host_in.addr[9:1] == kb[9:1];
    wire dma = cfg_in.ide_enable && cfg_in.function_control_reg[1]
               && !drive_dma_ack_n_in;
    wire a2 = cfg_in.advanced_support_cfg[2];
    wire wo = host_in.wr && !host_in.rd;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_acc; cmd || ctl; endsequence
    property p_cs0; cmd |=> !c0 && c1; endproperty
    a_cs0: assert property (p_cs0) else $error("cs0 wrong");
    property p_cs1; ctl |=> !c1 && c0; endproperty
    a_cs1: assert property (p_cs1) else $error("cs1 wrong");
    property p_lo; s_acc |=> !lo; endproperty
    a_lo: assert property (p_lo) else $error("low latch wrong");
    property p_hi; cmd && !io_cs16_n_in && !a2 |=> !hi; endproperty
    a_hi: assert property (p_hi) else $error("high latch wrong");
    property p_asc; a2 |=> hi; endproperty
    a_asc: assert property (p_asc) else $error("wide select used");
    property p_dis; !cfg_in.ide_enable |=> lo && hi && c0 && c1; endproperty
    a_dis: assert property (p_dis) else $error("disabled active");
    property p_d7;
        (cmd || ctl && !host_in.addr[0]) && wo |=>
            !oe && d7 == $past(host_data_in[7]);
    endproperty
    a_d7: assert property (p_d7) else $error("bit7 not driven");
    property p_flt; ctl && host_in.addr[0] |=> oe; endproperty
    a_flt: assert property (p_flt) else $error("bit7 not floating");
    property p_dma; dma |=> !c0 && !lo; endproperty
    a_dma: assert property (p_dma) else $error("dma ack ignored");
    property p_idle; !cmd && !ctl && !dma |=> lo && hi; endproperty
    a_idle: assert property (p_idle) else $error("latch not idle");
endmodule : ide_glue_asserts
bind ide_glue ide_glue_asserts u_chk (.*);

/* ide_glue_drive.sv */
// Drive model: 16-bit answer on both command blocks, bit 7 read data.
// Assumes the drive sees the host address.
module ide_glue_drive import ide_glue_pkg::*; (
    input  wire logic       core_clk_in,
    input  wire logic [9:0] addr_in,
    input  wire logic       wide_in,
    output logic            cs16_n_out,
    output logic            bit7_out);
    timeunit 1ns; timeprecision 1ns;
    logic tog_reg = 1'b0;
    always_ff @(posedge core_clk_in) tog_reg <= !tog_reg;
    assign bit7_out = tog_reg;
    assign cs16_n_out = !(wide_in && (addr_in[9:3] == PRI_CMD_BASE[9:3] ||
                        addr_in[9:3] == SEC_CMD_BASE[9:3]));
endmodule : ide_glue_drive

/* test_ide_glue.sv */
// Bench for the drive glue: reset check, access table, AEN, read bit 7 and mid reset tests, then verdict.
// Assumes the glue, its checker and the drive model are compiled first.
module test_ide_glue import ide_glue_pkg::*;;
    timeunit 1ns; timeprecision 1ns;
    typedef struct packed {
        logic [9:0] a;
        logic [7:0] c;
        logic [4:0] e;
    } igl_row_s;
    igl_row_s rows [12] = '{'{10'h1F0, 8'h69, 5'h08}, '{10'h1F7, 8'hA1, 5'h0B},
        '{10'h3F6, 8'h61, 5'h12}, '{10'h3F7, 8'h61, 5'h13},
        '{10'h170, 8'h79, 5'h08}, '{10'h377, 8'hB1, 5'h13},
        '{10'h1F0, 8'h79, 5'h1F}, '{10'h1F0, 8'h49, 5'h1F},
        '{10'h1F0, 8'h6D, 5'h0A}, '{10'h000, 8'hA2, 5'h0B},
        '{10'h000, 8'hA0, 5'h1F}, '{10'h1F0, 8'h29, 5'h1F}};
    ide_glue_host_s host = '0;
    ide_glue_cfg_s  cfg = '0;
    logic [7:0] hd = 8'h00;
    logic clk = 1'b0, rst_n = 1'b0, ack_n = 1'b1, wide = 1'b0;
    logic cs16_n, d7m, d7o, oe_n, h7, c0, c1, lo, hi;
    int error_cnt = 0, compares = 0;
    wire d7w = oe_n ? d7m : d7o;
    always #25 clk = !clk;
    ide_glue dut (.core_clk_in(clk), .arst_n_in(rst_n), .host_in(host),
        .cfg_in(cfg), .host_data_in(hd), .drive_dma_ack_n_in(ack_n),
        .io_cs16_n_in(cs16_n), .drive_data_bit7_in(d7w),
        .drive_data_bit7_out(d7o), .drive_data_bit7_oe_n_out(oe_n),
        .host_data_bit7_out(h7), .drive_chip_select_0_n_out(c0),
        .drive_chip_select_1_n_out(c1), .low_byte_latch_en_n_out(lo),
        .high_byte_latch_en_n_out(hi));
    ide_glue_drive mdl (.core_clk_in(clk), .addr_in(host.addr),
        .wide_in(wide), .cs16_n_out(cs16_n), .bit7_out(d7m));
    task automatic check(string nm, logic [4:0] seen, logic [4:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (16) @(negedge clk);
        check("reset", {c0, c1, lo, hi, oe_n}, 5'h1F);
        $display("reset test done");
        @(posedge clk) rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk);
            host <= '{rows[i].a, rows[i].c[7], rows[i].c[6], 1'b0};
            {cfg.ide_enable, cfg.secondary, wide} <= rows[i].c[5:3];
            cfg.advanced_support_cfg <= {5'h00, rows[i].c[2], 2'h0};
            cfg.function_control_reg <= {6'h00, rows[i].c[1], 1'b0};
            ack_n <= rows[i].c[0];
            hd <= {i[0], 7'h00};
            @(posedge clk);
            @(negedge clk);
            check("row", {c0, c1, lo, hi, oe_n},
                rows[i].e);
            if (!rows[i].e[0])
                check("d7", d7o, i[0]);
        end
        $display("table test done");
        // AEN high blocks the I/O decode
        @(posedge clk);
        host <= '{10'h1F0, 1'b0, 1'b1, 1'b1};
        cfg  <= '{1'b1, 1'b0, 8'h00, 8'h00};
        ack_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check("aen", {c0, c1, lo, hi, oe_n}, 5'h1F);
        $display("aen test done");
        // Read path: bit 7 from the drive, one cycle late
        @(posedge clk);
        host <= '{10'h1F0, 1'b1, 1'b0, 1'b0};
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("rd7", h7, !d7m);
        @(negedge clk);
        check("rd7", h7, !d7m);
        $display("read bit7 test done");
        // Reset in the middle of a write
        @(posedge clk);
        host <= '{10'h1F0, 1'b0, 1'b1, 1'b0};
        @(posedge clk) rst_n <= 1'b0;
        @(negedge clk);
        check("mid reset", {c0, c1, lo, hi, oe_n}, 5'h1F);
        @(posedge clk) rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check("after reset", {c0, c1, lo, hi, oe_n}, 5'h08);
        $display("mid reset test done");
        give_verdict();
    end
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end
endmodule : test_ide_glue
